//--- rtl/psram_seq_defs.vh
/*
 * Constants for the memory power-up and hardware-reset sequencer.
 * Assumes a 10 MHz system clock; included by the sequencer sources.
 */
// Summary of operation
// - Finish self-initialization within 150 us, then ready
// - Init wait starts only after reset released
// - Reset low returns device to idle standby
// - Reset restores configuration registers to defaults
// - Reset stops refresh, clears row counter
`ifndef PSRAM_SEQ_DEFS_VH
`define PSRAM_SEQ_DEFS_VH

`define CLK_PERIOD_NS        100
`define INIT_WAIT_TIME_US    150
// Longest time: round down
`define INIT_WAIT_CYCLES     ((`INIT_WAIT_TIME_US * 1000) / `CLK_PERIOD_NS)
// Pin edge to ready: sample slip, two sync stages, state register
`define INIT_PIPE_CYCLES     4
`define CLEAR_PULSE_MIN_WIDTH_NS 200
`define RELEASE_TO_SELECT_GAP_NS 200
`define ASSERT_TO_SELECT_GAP_NS  400

`define ROW_BITS             13
`define ROW_DEFAULT          13'h0000
`define REFRESH_INTERVAL     8
`define CFG_WIDTH            16
`define CFG0_DEFAULT         16'h8f1f
`define CFG1_DEFAULT         16'h0002

`define ST_RESET             2'h0
`define ST_INIT              2'h1
`define ST_READY             2'h2

`endif

//--- rtl/psram_refresh_row.v
/*
 * Self-refresh row walker: issues one refresh pulse per interval
 * and steps the row address. Assumes run is low while reset is held.
 */
`timescale 1ns/10ps
`include "psram_seq_defs.vh"

module psram_refresh_row
#(
	parameter ROW_BITS = `ROW_BITS,
	parameter INTERVAL = `REFRESH_INTERVAL
)
(
	// Clock and reset
	input  wire                sys_clk,
	input  wire                rst_n,
	// Control
	input  wire                run,
	// Refresh output
	output reg                 refresh_pulse_r,
	output reg  [ROW_BITS-1:0] refresh_row_r
);

	reg  [15:0]          gap_r;

	always @(posedge sys_clk)
	begin
		if (!rst_n || !run)
		begin
			gap_r           <= 16'h0000;
			refresh_pulse_r <= 1'b0;
			refresh_row_r   <= `ROW_DEFAULT;
		end
		else if (gap_r == INTERVAL[15:0] - 16'h0001)
		begin
			gap_r           <= 16'h0000;
			refresh_pulse_r <= 1'b1;
			refresh_row_r   <= refresh_row_r + {{(ROW_BITS-1){1'b0}}, 1'b1};
		end
		else
		begin
			gap_r           <= gap_r + 16'h0001;
			refresh_pulse_r <= 1'b0;
		end
	end

endmodule // psram_refresh_row

//--- rtl/psram_power_seq.v
/*
 * Power-up and hardware-reset sequencer of the pseudo-static memory.
 * Assumes power-on is signalled by the system reset rst_n; the memory's
 * reset and select pins come from another clock and are synchronised.
 * Array refresh during init and operation uses the row walker.
 * Ready rises no later than INIT_CYCLES clocks after the reset pin
 * goes high, sync latency included; a reset pin low for two clocks
 * or more is always seen. Configuration writes are expected only
 * while ready; any earlier write is dropped. Select is watched
 * only to flag an access during the init wait.
 */
`timescale 1ns/10ps
`include "psram_seq_defs.vh"

module psram_power_seq
#(
	parameter INIT_CYCLES = `INIT_WAIT_CYCLES,
	parameter ROW_BITS    = `ROW_BITS,
	parameter CFG_WIDTH   = `CFG_WIDTH
)
(
	// Clock and power-on reset
	input  wire                 sys_clk,
	input  wire                 rst_n,
	// Memory pins
	input  wire                 mem_reset_n,
	input  wire                 mem_select_n,
	// Configuration writes from the transaction engine
	input  wire                 cfg_wr,
	input  wire                 cfg_sel,
	input  wire [CFG_WIDTH-1:0] cfg_wdata,
	// Status
	output reg                  ready_r,
	output reg                  initializing_r,
	output reg                  standby_r,
	output reg                  early_select_r,
	output reg  [CFG_WIDTH-1:0] cfg0_r,
	output reg  [CFG_WIDTH-1:0] cfg1_r,
	// Refresh
	output wire                 refresh_pulse,
	output wire [ROW_BITS-1:0]  refresh_row
);

	// Wait shortened by the pin latency so ready meets the deadline
	localparam INIT_LAST = INIT_CYCLES - `INIT_PIPE_CYCLES;
	localparam PIN_COUNT = 2;
	// Level per pin while the stages fill: reset held, select idle
	localparam [PIN_COUNT-1:0] PIN_IDLE = 2'h2;

	wire [PIN_COUNT-1:0] pin_raw;
	wire [PIN_COUNT-1:0] pin_sync;
	reg  [1:0]           state_r;
	reg  [1:0]           state_nxt;
	reg  [31:0]          count_r;
	reg  [31:0]          count_nxt;
	wire                 hw_reset_n;
	wire                 select_seen;
	wire                 refresh_run;
	wire                 leave_init;
	wire                 cfg0_take;
	wire                 cfg1_take;

	assign pin_raw = {mem_select_n, mem_reset_n};

	// Two-stage synchroniser per pin
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1)
		begin : g_pin_sync
			reg  [1:0] stage_r;

			always @(posedge sys_clk)
			begin
				if (!rst_n)
					stage_r <= {2{PIN_IDLE[g]}};
				else
					stage_r <= {stage_r[0], pin_raw[g]};
			end

			assign pin_sync[g] = stage_r[1];
		end
	endgenerate

	assign hw_reset_n  = pin_sync[0];
	assign select_seen = !pin_sync[1];
	assign leave_init  = (count_r >= INIT_LAST);

	// Sequencing state machine
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			`ST_RESET:
			begin
				if (hw_reset_n)
					state_nxt = `ST_INIT;
			end
			`ST_INIT:
			begin
				if (!hw_reset_n)
					state_nxt = `ST_RESET;
				else if (leave_init)
					state_nxt = `ST_READY;
			end
			`ST_READY:
			begin
				if (!hw_reset_n)
					state_nxt = `ST_RESET;
			end
			default:
			begin
				state_nxt = `ST_RESET;
			end
		endcase
	end

	// Init wait counter runs only while the reset pin stays high in init
	always @*
	begin
		if (state_r == `ST_INIT && hw_reset_n && !leave_init)
			count_nxt = count_r + 32'h1;
		else if (state_r == `ST_INIT && hw_reset_n)
			count_nxt = count_r;
		else
			count_nxt = 32'h0;
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
			state_r <= `ST_RESET;
		else
			state_r <= state_nxt;
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
			count_r <= 32'h0;
		else
			count_r <= count_nxt;
	end

	// Phase flags follow the next state so they change with it
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			ready_r <= 1'b0;
		else
			ready_r <= (state_nxt == `ST_READY);
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
			initializing_r <= 1'b0;
		else
			initializing_r <= (state_nxt == `ST_INIT);
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n)
			standby_r <= 1'b1;
		else
			standby_r <= (state_nxt != `ST_INIT);
	end

	// Sticky until reset: select seen during init
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			early_select_r <= 1'b0;
		else if (state_r == `ST_RESET)
			early_select_r <= 1'b0;
		else if (select_seen && state_r == `ST_INIT)
			early_select_r <= 1'b1;
	end

	// Configuration registers; writes land only once ready
	assign cfg0_take = cfg_wr && !cfg_sel && (state_r == `ST_READY);
	assign cfg1_take = cfg_wr && cfg_sel && (state_r == `ST_READY);

	always @(posedge sys_clk)
	begin
		if (!rst_n || !hw_reset_n)
			cfg0_r <= `CFG0_DEFAULT;
		else if (cfg0_take)
			cfg0_r <= cfg_wdata;
	end

	always @(posedge sys_clk)
	begin
		if (!rst_n || !hw_reset_n)
			cfg1_r <= `CFG1_DEFAULT;
		else if (cfg1_take)
			cfg1_r <= cfg_wdata;
	end

	// Refresh halts while the reset pin is low; the walker then
	// restarts from its default row
	assign refresh_run = (state_r != `ST_RESET) && hw_reset_n;

	psram_refresh_row
	#(
		.ROW_BITS (ROW_BITS),
		.INTERVAL (`REFRESH_INTERVAL)
	)
	u_refresh
	(
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.run             (refresh_run),
		.refresh_pulse_r (refresh_pulse),
		.refresh_row_r   (refresh_row)
	);

endmodule // psram_power_seq

//--- tb/psram_power_seq_asserts.sv
/* Checker for the power-up sequencer.
   Assumes binding to the sequencer ports. */
`timescale 1ns/10ps
module psram_power_seq_asserts
#(
	parameter int INIT_CYCLES = 20
)
(
	input wire        sys_clk,
	input wire        rst_n,
	input wire        mem_reset_n,
	input wire        ready_r,
	input wire        initializing_r,
	input wire        standby_r,
	input wire [15:0] cfg0_r,
	input wire [15:0] cfg1_r,
	input wire        refresh_pulse,
	input wire [12:0] refresh_row
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	int wait_cnt_r = 0;
	// Cycles since the reset pin went high without ready
	always @(posedge sys_clk)
	begin
		if (!rst_n || !mem_reset_n || ready_r)
			wait_cnt_r <= 0;
		else
			wait_cnt_r <= wait_cnt_r + 1;
	end
	init_deadline_a:
	assert property (wait_cnt_r <= INIT_CYCLES) else $error("ready past deadline");
	init_bound_a:
	assert property (initializing_r |-> ##[1:INIT_CYCLES] !initializing_r) else $error("init too long");
	ready_source_a:
	assert property ($rose(ready_r) |-> $past(initializing_r)) else $error("ready without init");
	hold_idle_a:
	assert property (!mem_reset_n [*5] |-> standby_r && !ready_r && !initializing_r) else $error("not idle");
	cfg_default_a:
	assert property (!mem_reset_n [*5] |-> cfg0_r == 16'h8f1f && cfg1_r == 16'h0002) else $error("cfg kept");
	refresh_stop_a:
	assert property (!mem_reset_n [*5] |-> !refresh_pulse && refresh_row == 13'h0000) else $error("refresh on");
endmodule // psram_power_seq_asserts

//--- tb/host_model.sv
/* Host controller driving reset and select.
   Assumes a 100 ns clock; rst_req holds reset. */
`timescale 1ns/10ps
module host_model
(
	input wire sys_clk,
	input wire rst_req,
	input wire sel_req,
	input wire dev_ready,
	output reg mem_reset_n = 1'b0,
	output reg mem_select_n = 1'b1
);
	int cnt = 0;
	always @(posedge sys_clk)
	begin
		cnt <= cnt + 1;
		if (rst_req)
		begin
			mem_reset_n <= 1'b0;
			mem_select_n <= 1'b1;
			cnt <= 0;
		end
		else if (cnt >= 2)
			mem_reset_n <= 1'b1;
		if (!rst_req && cnt >= 4 && dev_ready)
			mem_select_n <= !sel_req;
	end
endmodule // host_model

//--- tb/tb_psram_power_seq.sv
/* Testbench of the power-up sequencer.
   Assumes the 10 MHz clock and INIT_CYCLES of 20. */
`timescale 1ns/10ps
module tb_psram_power_seq;
	reg        sys_clk = 0, rst_n = 0, rst_req = 1, sel_req = 0, cfg_wr = 0, cfg_sel = 0;
	reg [15:0] cfg_wdata = 16'h0000;
	wire       mem_reset_n, mem_select_n, ready_r, initializing_r, standby_r, early_select_r, refresh_pulse;
	wire [15:0] cfg0_r, cfg1_r;
	wire [12:0] refresh_row;
	localparam int INIT = 20;
	int        error_cnt = 0, n_tests = 0, seed = 32'hf8fce9d3, i, t, e0 = 16'h8f1f, e1 = 16'h0002;
	int        pulses, seen_init;
	initial forever #50 sys_clk = ~sys_clk;
	psram_power_seq #(.INIT_CYCLES(INIT)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .mem_reset_n(mem_reset_n),
		.mem_select_n(mem_select_n), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .ready_r(ready_r),
		.initializing_r(initializing_r), .standby_r(standby_r), .early_select_r(early_select_r), .cfg0_r(cfg0_r),
		.cfg1_r(cfg1_r), .refresh_pulse(refresh_pulse), .refresh_row(refresh_row));
	host_model host_u (.sys_clk(sys_clk), .rst_req(rst_req), .sel_req(sel_req), .dev_ready(ready_r),
		.mem_reset_n(mem_reset_n), .mem_select_n(mem_select_n));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1;
		for (i = 0; i < 2; i++)
		begin
			repeat (10 + $unsigned($random(seed)) % 8) @(posedge sys_clk);
			cfg_wr <= 1;
			cfg_wdata <= $random(seed);
			@(posedge sys_clk);
			cfg_wr <= 0;
			repeat (2) @(negedge sys_clk);
			chk(ready_r, 0);
			chk(initializing_r, 0);
			chk(standby_r, 1);
			chk(early_select_r, 0);
			chk({3'h0, refresh_row}, 0);
			chk(refresh_pulse, 0);
			chk(cfg0_r, e0);
			chk(cfg1_r, e1);
			@(posedge sys_clk);
			rst_req <= 0;
			sel_req <= $random(seed);
			pulses = 0;
			seen_init = 0;
			for (t = 0; t < 40 && ready_r !== 1'b1; t++)
			begin
				@(negedge sys_clk);
				pulses += (refresh_pulse === 1'b1);
				seen_init += (initializing_r === 1'b1);
			end
			if (t == 40)
			begin
				error_cnt++;
				$display("CHECK FAILED %0t ready timeout", $time);
				end_sim;
			end
			// Reset pin rises three edges after this wait starts
			chk(t >= INIT + 1 && t <= INIT + 4, 1);
			chk(seen_init != 0, 1);
			chk(initializing_r, 0);
			chk(early_select_r, 0);
			chk(pulses != 0, 1);
			chk({3'h0, refresh_row}, pulses);
			@(posedge sys_clk);
			cfg_sel <= i;
			cfg_wdata <= $random(seed);
			cfg_wr <= 1;
			@(posedge sys_clk);
			cfg_wr <= 0;
			if (i)
				e1 = cfg_wdata;
			else
				e0 = cfg_wdata;
			repeat (2) @(negedge sys_clk);
			chk(cfg0_r, e0);
			chk(cfg1_r, e1);
			@(posedge sys_clk);
			rst_req <= 1;
			e0 = 16'h8f1f;
			e1 = 16'h0002;
		end
		end_sim;
	end
endmodule // tb_psram_power_seq
bind psram_power_seq psram_power_seq_asserts #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
	.mem_reset_n(mem_reset_n), .ready_r(ready_r), .initializing_r(initializing_r), .standby_r(standby_r),
	.cfg0_r(cfg0_r), .cfg1_r(cfg1_r), .refresh_pulse(refresh_pulse), .refresh_row(refresh_row));
